// file: bench/tb_tbco_timer.sv
// Testbench for the timer in bit-rate and clock-out modes
module tb_tbco_timer
  import tbco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, trig = 1'b1, fovf = 1'b0, perr;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, pslv, txt, rxt, cko, irq;
  logic cpin = 1'b1;
  int miscompares = 0, tests_run = 0, txg, txn, rxn, n, t, r, bitg;
  always #2 clk = ~clk;
  tbco_timer u_tbco_timer (.CLK_SYS_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hF), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(pslv), .EXTERNAL_TRIGGER_PIN_I(trig),
    .EXTERNAL_COUNT_PIN_I(cpin), .FIRST_TIMER_OVF_I(fovf), .TX_RATE_TICK_O(txt),
    .RX_RATE_TICK_O(rxt), .CLOCK_OUT_PIN_O(cko), .IRQ_O(irq));
  tbco_uart_model u_tbco_uart_model (.clk_i(clk), .rst_b_i(rst_b), .tx_tick_i(txt),
    .rx_tick_i(rxt), .tx_gap_o(txg), .tx_n_o(txn), .rx_n_o(rxn), .tx_div_o(),
    .bit_gap_o(bitg));
  task finish_test;
    if (miscompares == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (prdy !== 1'b1 && k < 20);
    chk("ready", prdy, 1'b1);
    if (prdy !== 1'b1)
      finish_test;
    rd = prd;
    perr = pslv;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdr(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  // Edges between two clock pin changes; a stuck pin ends the run
  task hp;
    logic v;
    for (int i = 0; i < 2; i++)
    begin
      v = cko;
      n = 0;
      while (cko === v && n < 300)
      begin
        @(posedge clk);
        n++;
      end
    end
    if (n >= 300)
    begin
      miscompares++;
      finish_test;
    end
  endtask
  task pulse;
    fovf <= 1'b1;
    @(posedge clk);
    fovf <= 1'b0;
  endtask
  initial
  begin
    cyc(8);
    rst_b <= 1'b1;
    @(posedge clk);
    rdr(TBCO_OFF_MODE);
    chk("mode rst", rd, 32'h0);
    wr(TBCO_OFF_MODE, 32'h3);
    rdr(TBCO_OFF_MODE);
    chk("mode", rd, 32'h3);
    rdr(8'h18);
    chk("slverr", perr, 1'b1);
    wr(TBCO_OFF_MODE, 32'h0);
    pulse;
    chk("tx first", txt, 1'b1);
    chk("rx first", rxt, 1'b1);
    wr(TBCO_OFF_CTRL, 32'h10);
    pulse;
    chk("tx own", txt, 1'b0);
    chk("rx first", rxt, 1'b1);
    wr(TBCO_OFF_RELOAD, 32'hFFF0);
    wr(TBCO_OFF_CNT, 32'hFFF0);
    wr(TBCO_OFF_IRQ_MASK, 32'h3);
    t = txn;
    r = rxn;
    wr(TBCO_OFF_CTRL, 32'h3D);
    cyc(1100);
    chk("gap", txg, 32);
    chk("bit gap", bitg, 512);
    chk("rx n", rxn - r, txn - t);
    chk("irq", irq, 1'b0);
    trig <= 1'b0;
    cyc(45);
    chk("gap trig", txg, 32);
    rdr(TBCO_OFF_CTRL);
    chk("ctrl", rd, 32'h7D);
    chk("irq ext", irq, 1'b1);
    wr(TBCO_OFF_IRQ_STAT, 32'h2);
    chk("irq clr", irq, 1'b0);
    wr(TBCO_OFF_MODE, 32'h2);
    hp;
    chk("cko half", n, 32);
    wr(TBCO_OFF_CTRL, 32'h30);
    cyc(2);
    t = txn;
    cyc(100);
    chk("stopped", txn, t);
    wr(TBCO_OFF_RELOAD, 32'hFFF0);
    wr(TBCO_OFF_CNT, 32'hFFF0);
    wr(TBCO_OFF_CTRL, 32'h04);
    hp;
    chk("cko only", n, 32);
    chk("tx idle", txn, t);
    chk("irq cko", irq, 1'b0);
    wr(TBCO_OFF_MODE, 32'h0);
    wr(TBCO_OFF_CTRL, 32'h0);
    wr(TBCO_OFF_CNT, 32'hFFF0);
    wr(TBCO_OFF_CTRL, 32'h04);
    cyc(170);
    rdr(TBCO_OFF_CTRL);
    chk("slow", rd, 32'h04);
    cyc(40);
    rdr(TBCO_OFF_CTRL);
    chk("ovf", rd, 32'h84);
    chk("irq ovf", irq, 1'b1);
    wr(TBCO_OFF_IRQ_MASK, 32'h0);
    chk("irq masked", irq, 1'b0);
    // Counter select in rate mode: two pin falls from FFFE give one own tick
    wr(TBCO_OFF_CTRL, 32'h0);
    wr(TBCO_OFF_CNT, 32'hFFFE);
    wr(TBCO_OFF_CTRL, 32'h16);
    t = txn;
    repeat (2)
    begin
      cpin <= 1'b0;
      cyc(6);
      cpin <= 1'b1;
      cyc(6);
    end
    chk("count pin", txn - t, 1);
    finish_test;
  end
endmodule

// file: bench/tbco_timer_sva.sv
// Port-level checker for the timer block
module tbco_timer_sva
  import tbco_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic FIRST_TIMER_OVF_I,
  input wire logic TX_RATE_TICK_O,
  input wire logic RX_RATE_TICK_O,
  input wire logic CLOCK_OUT_PIN_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  wire logic acc = PSEL_I && PENABLE_I;
  wire logic hit = PADDR_I inside {TBCO_OFF_CTRL, TBCO_OFF_MODE, TBCO_OFF_CNT,
    TBCO_OFF_RELOAD, TBCO_OFF_IRQ_STAT, TBCO_OFF_IRQ_MASK};
  // Own ticks are spaced two cycles at least, so one never runs on
  a_tx_tick_one:
    assert property (TX_RATE_TICK_O && !FIRST_TIMER_OVF_I |=> !TX_RATE_TICK_O)
    else $error("tx tick too long");
  a_rx_tick_one:
    assert property (RX_RATE_TICK_O && !FIRST_TIMER_OVF_I |=> !RX_RATE_TICK_O)
    else $error("rx tick too long");
  a_cko_half_min:
    assert property ($changed(CLOCK_OUT_PIN_O) |=> $stable(CLOCK_OUT_PIN_O))
    else $error("clock pin toggled twice running");
  a_ready_no_wait:
    assert property (acc |-> PREADY_O)
    else $error("ready low in access");
  a_err_unmapped:
    assert property (acc && !hit |-> PSLVERR_O)
    else $error("no error on unmapped address");
  a_err_mapped:
    assert property (acc && hit |-> !PSLVERR_O)
    else $error("error on mapped address");
  a_err_read_zero:
    assert property (acc && !PWRITE_I && PSLVERR_O |-> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  a_mask_off_irq:
    assert property (acc && PWRITE_I && PADDR_I == TBCO_OFF_IRQ_MASK && PSTRB_I[0]
      && PWDATA_I[1:0] == 2'h0 |=> !IRQ_O)
    else $error("irq high with mask clear");
endmodule
bind tbco_timer tbco_timer_sva u_tbco_timer_sva (.CLK_SYS_I(CLK_SYS_I), .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
  .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .FIRST_TIMER_OVF_I(FIRST_TIMER_OVF_I),
  .TX_RATE_TICK_O(TX_RATE_TICK_O), .RX_RATE_TICK_O(RX_RATE_TICK_O),
  .CLOCK_OUT_PIN_O(CLOCK_OUT_PIN_O), .IRQ_O(IRQ_O));

// file: bench/tbco_uart_model.sv
// Serial port model that consumes the bit-rate ticks
module tbco_uart_model
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic tx_tick_i,
  input wire logic rx_tick_i,
  output int tx_gap_o,
  output int tx_n_o,
  output int rx_n_o,
  output logic [3:0] tx_div_o,
  output int bit_gap_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  int bcnt;
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt <= 0;
      bcnt <= 0;
      bit_gap_o <= 0;
      tx_gap_o <= 0;
      tx_n_o <= 0;
      rx_n_o <= 0;
      tx_div_o <= 4'h0;
    end
    else
    begin
      cnt <= tx_tick_i ? 1 : cnt + 1;
      // Bit period: cycles between two sixteenth ticks
      bcnt <= (tx_tick_i && tx_div_o == 4'hF) ? 1 : bcnt + 1;
      if (tx_tick_i && tx_div_o == 4'hF)
        bit_gap_o <= bcnt;
      // Each tick must count once, every sixteenth makes one bit
      if (tx_tick_i)
      begin
        tx_gap_o <= cnt;
        tx_n_o <= tx_n_o + 1;
        tx_div_o <= tx_div_o + 4'h1;
      end
      if (rx_tick_i)
        rx_n_o <= rx_n_o + 1;
    end
  end
endmodule

// file: hdl/tbco_pkg.sv
// Package of register offsets, field positions, reset values and timing for the timer block
package tbco_pkg;
  // APB word offsets (byte addresses)
  localparam logic [7:0] TBCO_OFF_CTRL = 8'h00;
  localparam logic [7:0] TBCO_OFF_MODE = 8'h04;
  localparam logic [7:0] TBCO_OFF_CNT = 8'h08;
  localparam logic [7:0] TBCO_OFF_RELOAD = 8'h0C;
  localparam logic [7:0] TBCO_OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] TBCO_OFF_IRQ_MASK = 8'h14;
  // Control register field positions
  localparam int TBCO_CTRL_OVF = 7;
  localparam int TBCO_CTRL_EXT_FLAG = 6;
  localparam int TBCO_CTRL_RX_SEL = 5;
  localparam int TBCO_CTRL_TX_SEL = 4;
  localparam int TBCO_CTRL_EXT_EN = 3;
  localparam int TBCO_CTRL_RUN = 2;
  localparam int TBCO_CTRL_CNT_SEL = 1;
  localparam int TBCO_CTRL_CAP_SEL = 0;
  // Mode register field positions
  localparam int TBCO_MODE_CKO_EN = 1;
  localparam int TBCO_MODE_DOWN_EN = 0;
  // Interrupt status / mask bit positions
  localparam int TBCO_IRQ_OVF = 0;
  localparam int TBCO_IRQ_EXT = 1;
  // Reset values
  localparam logic [7:0] TBCO_CTRL_RST = 8'h00;
  localparam logic [1:0] TBCO_MODE_RST = 2'h0;
  localparam logic [15:0] TBCO_CNT_RST = 16'h0000;
  localparam logic [15:0] TBCO_RELOAD_RST = 16'h0000;
  localparam logic [1:0] TBCO_IRQ_RST = 2'h0;
  // Timing
  localparam int TBCO_BRG_DIV = 2;
  localparam int TBCO_TIMER_DIV = 12;
endpackage

// file: hdl/tbco_sync.sv
// Three-stage synchroniser for a pin input with agreement-based change detection
module tbco_sync
  import tbco_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      lvl_q <= RESET_LEVEL;
    else if (s2_q == s3_q)
      lvl_q <= s3_q;
  end

  assign level_o = lvl_q;
  assign fall_o = lvl_q && (s2_q == s3_q) && !s3_q;
endmodule

// file: hdl/tbco_timer.sv
// Sixteen-bit timer as bit-rate generator and square-wave clock source, with APB registers
//
// The implementer's own choices: the address map and register access over APB.
module tbco_timer
  import tbco_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic EXTERNAL_TRIGGER_PIN_I,
  input wire logic EXTERNAL_COUNT_PIN_I,
  input wire logic FIRST_TIMER_OVF_I,
  output logic TX_RATE_TICK_O,
  output logic RX_RATE_TICK_O,
  output logic CLOCK_OUT_PIN_O,
  output logic IRQ_O
);
  logic [7:0] ctrl_q;
  logic [1:0] mode_q;
  logic [15:0] cnt_q;
  logic [15:0] reload_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [3:0] pre_q;
  logic cko_q;
  logic ovf_tick_q;
  logic [31:0] prdata_q;
  logic trig_fall;
  logic cnt_fall;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic brg_mode;
  logic cko_mode;
  logic run;
  logic time_base;
  logic inc;
  logic rollover;
  logic ext_reload;
  logic set_ovf;
  logic set_ext;

  tbco_sync #(.RESET_LEVEL(1'b1)) u_trig_sync
  (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .pin_i(EXTERNAL_TRIGGER_PIN_I),
    .level_o(),
    .fall_o(trig_fall)
  );

  tbco_sync #(.RESET_LEVEL(1'b1)) u_cnt_sync
  (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .pin_i(EXTERNAL_COUNT_PIN_I),
    .level_o(),
    .fall_o(cnt_fall)
  );

  // Bus decode; every access completes with no wait state
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign addr_ok = (PADDR_I == TBCO_OFF_CTRL) || (PADDR_I == TBCO_OFF_MODE)
    || (PADDR_I == TBCO_OFF_CNT) || (PADDR_I == TBCO_OFF_RELOAD)
    || (PADDR_I == TBCO_OFF_IRQ_STAT) || (PADDR_I == TBCO_OFF_IRQ_MASK);
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

  assign run = ctrl_q[TBCO_CTRL_RUN];
  assign brg_mode = ctrl_q[TBCO_CTRL_TX_SEL] || ctrl_q[TBCO_CTRL_RX_SEL];
  assign cko_mode = mode_q[TBCO_MODE_CKO_EN];

  // Prescaler: /2 when generating rates or clock-out, /12 for plain timing
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      pre_q <= 4'h0;
    else if (!run || time_base)
      pre_q <= 4'h0;
    else
      pre_q <= pre_q + 4'h1;
  end

  assign time_base = (brg_mode || cko_mode)
    ? (pre_q == 4'(TBCO_BRG_DIV - 1))
    : (pre_q == 4'(TBCO_TIMER_DIV - 1));

  assign inc = run && (ctrl_q[TBCO_CTRL_CNT_SEL] ? cnt_fall : time_base);
  assign rollover = inc && (cnt_q == 16'hFFFF);
  // Auto-reload is forced while a rate select is set, capture select ignored
  assign ext_reload = trig_fall && ctrl_q[TBCO_CTRL_EXT_EN] && !brg_mode
    && !ctrl_q[TBCO_CTRL_CAP_SEL] && !cko_mode;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cnt_q <= TBCO_CNT_RST;
    else if (wr_en && PADDR_I == TBCO_OFF_CNT)
    begin
      if (PSTRB_I[0])
        cnt_q[7:0] <= PWDATA_I[7:0];
      if (PSTRB_I[1])
        cnt_q[15:8] <= PWDATA_I[15:8];
    end
    else if (rollover || ext_reload)
      cnt_q <= reload_q;
    else if (inc)
      cnt_q <= cnt_q + 16'h0001;
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      reload_q <= TBCO_RELOAD_RST;
    else if (wr_en && PADDR_I == TBCO_OFF_RELOAD)
    begin
      if (PSTRB_I[0])
        reload_q[7:0] <= PWDATA_I[7:0];
      if (PSTRB_I[1])
        reload_q[15:8] <= PWDATA_I[15:8];
    end
  end

  // One-cycle overflow tick shared by serial rates and clock-out
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ovf_tick_q <= 1'b0;
    else
      ovf_tick_q <= rollover;
  end

  assign TX_RATE_TICK_O = ctrl_q[TBCO_CTRL_TX_SEL] ? ovf_tick_q : FIRST_TIMER_OVF_I;
  assign RX_RATE_TICK_O = ctrl_q[TBCO_CTRL_RX_SEL] ? ovf_tick_q : FIRST_TIMER_OVF_I;

  // Toggle per overflow at clock/2 counting gives clock/(4*(65536-reload))
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      cko_q <= 1'b0;
    else if (!cko_mode)
      cko_q <= 1'b0;
    else if (ovf_tick_q)
      cko_q <= !cko_q;
  end
  assign CLOCK_OUT_PIN_O = cko_q;

  // Overflow flag only in plain timer use, not as rate or clock source
  assign set_ovf = rollover && !brg_mode && !cko_mode;
  assign set_ext = trig_fall && ctrl_q[TBCO_CTRL_EXT_EN];

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      ctrl_q <= TBCO_CTRL_RST;
    else
    begin
      if (wr_en && PADDR_I == TBCO_OFF_CTRL && PSTRB_I[0])
        ctrl_q <= PWDATA_I[7:0];
      // Hardware set wins over a software write in the same cycle
      if (set_ovf)
        ctrl_q[TBCO_CTRL_OVF] <= 1'b1;
      if (set_ext)
        ctrl_q[TBCO_CTRL_EXT_FLAG] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      mode_q <= TBCO_MODE_RST;
    else if (wr_en && PADDR_I == TBCO_OFF_MODE && PSTRB_I[0])
      mode_q <= PWDATA_I[1:0];
  end

  // Sticky status, write one to clear, event set wins
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      irq_stat_q <= TBCO_IRQ_RST;
    else
    begin
      if (wr_en && PADDR_I == TBCO_OFF_IRQ_STAT && PSTRB_I[0])
        irq_stat_q <= irq_stat_q & ~PWDATA_I[1:0];
      if (set_ovf)
        irq_stat_q[TBCO_IRQ_OVF] <= 1'b1;
      if (set_ext && !mode_q[TBCO_MODE_DOWN_EN])
        irq_stat_q[TBCO_IRQ_EXT] <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      irq_mask_q <= TBCO_IRQ_RST;
    else if (wr_en && PADDR_I == TBCO_OFF_IRQ_MASK && PSTRB_I[0])
      irq_mask_q <= PWDATA_I[1:0];
  end

  assign IRQ_O = |(irq_stat_q & irq_mask_q);

  // Read data captured in the setup cycle
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      prdata_q <= 32'h0000_0000;
    else if (rd_en)
    begin
      unique case (PADDR_I)
        TBCO_OFF_CTRL: prdata_q <= {24'h000000, ctrl_q};
        TBCO_OFF_MODE: prdata_q <= {30'h0, mode_q};
        TBCO_OFF_CNT: prdata_q <= {16'h0000, cnt_q};
        TBCO_OFF_RELOAD: prdata_q <= {16'h0000, reload_q};
        TBCO_OFF_IRQ_STAT: prdata_q <= {30'h0, irq_stat_q};
        TBCO_OFF_IRQ_MASK: prdata_q <= {30'h0, irq_mask_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end
  assign PRDATA_O = prdata_q;
endmodule
